//--- rtl/pmic_fault_supervisor.sv
// pmic_fault_supervisor: fault supervision, global restart, inlet fet and pin muxing
// assumes all inputs synchronous to core_clk; comparator levels come from analog
// Contract
// - output uv/ov fault turns all outputs off 100ms then reruns power-up
// - uv/ov flags always live; mask gates interrupt and the global off and restart
// - any output uv/ov fault pulls system reset low
// - buck current at 75% over 16 cycles sets flag, interrupt unless masked
// - current limit causing unmasked uv turns all supplies off 100ms, restarts
// - buck at 122% limit disables that buck, waits 14ms, restarts it
// - ldo current limit causing uv turns all supplies off 100ms
// - overcurrent protection always acts; mask only stops reporting
// - thermal warning sets live flag and interrupt unless masked
// - thermal shutdown flags fault and turns outputs off unless masked
// - input voltage within limits enables inlet fet gate
// - input overvoltage holds inlet fet off until clear, then restarts
// - input overvoltage sets no readable status bit
// - input current at 72.5% asserts interrupt unless warn mask set
// - input below monitor threshold asserts interrupt unless monitor mask set
// - power request filtered 10us both edges before sleep decision
// - each general pin takes one factory assigned function
// - pins one and two open-drain or push-pull, no led
// - pins three and four any function, open-drain only
// - external enable asserts after trigger event plus configured delay
// - external power good acts as sequencing trigger
// - interrupt releases only after fault clear and status read
// - system reset releases after 20-100ms delay once all good
`timescale 1ns/1ns
module pmic_fault_supervisor #(
    parameter int unsigned GLOBAL_OFF_CYC = fault_supervisor_pkg::GLOBAL_OFF_CYC,
    parameter int unsigned BUCK_RESTART_CYC = fault_supervisor_pkg::BUCK_RESTART_CYC,
    parameter int unsigned RST_STEP_CYC = fault_supervisor_pkg::RST_STEP_CYC,
    parameter int unsigned SEQ_DLY_UNIT_CYC = fault_supervisor_pkg::SEQ_DLY_UNIT_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [4:0] out_uv,
    input wire logic [4:0] out_ov,
    input wire logic [4:0] out_good,
    input wire logic [4:0] uvov_mask,
    input wire logic [2:0] buck_warn_level,
    input wire logic [2:0] buck_sw_tick,
    input wire logic [2:0] buck_hard_limit,
    input wire logic [1:0] ldo_limit,
    input wire logic [4:0] oc_mask,
    input wire logic therm_warn,
    input wire logic therm_shut,
    input wire logic therm_warn_mask,
    input wire logic therm_shut_mask,
    input wire logic input_voltage_sense_ok,
    input wire logic input_voltage_sense_ov,
    input wire logic input_current_warn,
    input wire logic input_current_warn_mask,
    input wire logic input_below_monitor,
    input wire logic input_monitor_mask,
    input wire logic status_read,
    input wire logic power_request_in,
    input wire logic [2:0] reset_release_delay,
    input wire logic [1:0] ext_trigger_sel,
    input wire logic [3:0] ext_delay_ms,
    input wire logic [11:0] pin_function,
    input wire logic [3:0] pin_push_pull,
    input wire logic [3:0] pin_gpio_out,
    input wire logic [3:0] pin_in,
    input wire logic external_power_good_in,
    output logic [4:0] out_enable,
    output logic [4:0] uvov_flag,
    output logic [2:0] buck_oc_flag,
    output logic therm_warn_flag,
    output logic therm_shut_flag,
    output logic [7:0] fault_status,
    output logic interrupt_out_n,
    output logic system_reset_out_n,
    output logic inlet_fet_gate,
    output logic external_supply_enable_out,
    output logic deep_sleep_state,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_INLET = 4'b0001,
        ST_UP = 4'b0010,
        ST_RUN = 4'b0100,
        ST_OFF = 4'b1000
    } seq_t;
    seq_t state_ff;
    logic [31:0] off_cnt_ff;
    logic [31:0] ext_cnt_ff;
    logic [31:0] rst_cnt_ff;
    logic [31:0] pf_cnt_ff;
    logic pwr_filt_ff;
    logic [4:0] uvov_any;
    logic global_trip;
    logic [4:0] cur_fault;
    logic [7:0] fault_cond;
    logic ext_trig;
    logic [31:0] ext_target;
    logic [31:0] rst_target;
    logic [3:0] pin_drive;
    logic [3:0] pin_od;

    assign uvov_any = out_uv | out_ov;
    // uv from current limit is the same uv trip, so limiting also restarts all
    assign global_trip = (|(uvov_any & ~uvov_mask)) |
                         (|(out_uv[4:3] & ldo_limit)) |
                         (therm_shut & ~therm_shut_mask);

    // global off and restart sequencing
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_INLET;
            off_cnt_ff <= 32'h0;
        end else begin
            unique case (state_ff)
                ST_INLET: begin
                    off_cnt_ff <= 32'h0;
                    if (inlet_fet_gate && !input_voltage_sense_ov) begin
                        state_ff <= ST_UP;
                    end
                end
                ST_UP, ST_RUN: begin
                    if (input_voltage_sense_ov || !input_voltage_sense_ok) begin
                        state_ff <= ST_INLET;
                    end else if (global_trip) begin
                        state_ff <= ST_OFF;
                        off_cnt_ff <= 32'h0;
                    end else if (state_ff == ST_UP && &out_good) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_OFF: begin
                    if (global_trip) begin
                        off_cnt_ff <= 32'h0;
                    end else if (off_cnt_ff >= GLOBAL_OFF_CYC - 1) begin
                        state_ff <= ST_UP;
                    end else begin
                        off_cnt_ff <= off_cnt_ff + 32'h1;
                    end
                end
            endcase
        end
    end

    // per output enables; bucks also run a local 14 ms restart
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_out
            if (gi < 3) begin : g_buck
                logic [31:0] hl_cnt_ff;
                logic hl_off_ff;
                logic [4:0] warn_cnt_ff;
                logic oc_ff;
                always_ff @(posedge core_clk or negedge resetn) begin
                    if (!resetn) begin
                        hl_cnt_ff <= 32'h0;
                        hl_off_ff <= 1'b0;
                    end else if (buck_hard_limit[gi]) begin
                        hl_off_ff <= 1'b1;
                        hl_cnt_ff <= 32'h0;
                    end else if (hl_off_ff) begin
                        if (hl_cnt_ff >= BUCK_RESTART_CYC - 1) begin
                            hl_off_ff <= 1'b0;
                        end else begin
                            hl_cnt_ff <= hl_cnt_ff + 32'h1;
                        end
                    end
                end
                // count switching cycles at the warning level
                always_ff @(posedge core_clk or negedge resetn) begin
                    if (!resetn) begin
                        warn_cnt_ff <= 5'h0;
                        oc_ff <= 1'b0;
                    end else if (!buck_warn_level[gi]) begin
                        warn_cnt_ff <= 5'h0;
                        oc_ff <= 1'b0;
                    end else if (buck_sw_tick[gi]) begin
                        if (warn_cnt_ff > fault_supervisor_pkg::WARN_CYCLES - 5'h1) begin
                            oc_ff <= 1'b1;
                        end else begin
                            warn_cnt_ff <= warn_cnt_ff + 5'h1;
                        end
                    end
                end
                assign cur_fault[gi] = oc_ff & ~oc_mask[gi];
                always_ff @(posedge core_clk or negedge resetn) begin
                    if (!resetn) begin
                        out_enable[gi] <= 1'b0;
                        buck_oc_flag[gi] <= 1'b0;
                    end else begin
                        out_enable[gi] <= (state_ff == ST_UP || state_ff == ST_RUN) &&
                                          !hl_off_ff && !buck_hard_limit[gi];
                        buck_oc_flag[gi] <= oc_ff;
                    end
                end
            end else begin : g_ldo
                assign cur_fault[gi] = ldo_limit[gi-3] & ~oc_mask[gi];
                always_ff @(posedge core_clk or negedge resetn) begin
                    if (!resetn) begin
                        out_enable[gi] <= 1'b0;
                    end else begin
                        out_enable[gi] <= (state_ff == ST_UP || state_ff == ST_RUN);
                    end
                end
            end
        end
    endgenerate

    // live flags, independent of masks
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            uvov_flag <= 5'h0;
            therm_warn_flag <= 1'b0;
            therm_shut_flag <= 1'b0;
        end else begin
            uvov_flag <= uvov_any;
            therm_warn_flag <= therm_warn;
            therm_shut_flag <= therm_shut;
        end
    end

    // sticky fault bits: set wins, clear on read only once condition gone
    assign fault_cond = {input_below_monitor & ~input_monitor_mask,
                         input_current_warn & ~input_current_warn_mask,
                         therm_shut & ~therm_shut_mask,
                         therm_warn & ~therm_warn_mask,
                         |(uvov_any & ~uvov_mask),
                         |cur_fault, 2'h0};
    // input overvoltage deliberately has no bit here
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fault_status <= 8'h0;
        end else if (status_read) begin
            fault_status <= fault_cond;
        end else begin
            fault_status <= fault_status | fault_cond;
        end
    end

    // inlet fet gate: on when input good, off while overvoltage present
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            inlet_fet_gate <= 1'b0;
        end else begin
            inlet_fet_gate <= input_voltage_sense_ok && !input_voltage_sense_ov;
        end
    end

    // power request filter, 10 us stable on either edge
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pf_cnt_ff <= 32'h0;
            pwr_filt_ff <= 1'b0;
        end else if (power_request_in == pwr_filt_ff) begin
            pf_cnt_ff <= 32'h0;
        end else if (pf_cnt_ff >= fault_supervisor_pkg::PWR_FILTER_CYC - 1) begin
            pwr_filt_ff <= power_request_in;
            pf_cnt_ff <= 32'h0;
        end else begin
            pf_cnt_ff <= pf_cnt_ff + 32'h1;
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            deep_sleep_state <= 1'b1;
        end else begin
            deep_sleep_state <= !pwr_filt_ff;
        end
    end

    // external enable: trigger plus delay during power-up
    always_comb begin
        unique case (ext_trigger_sel)
            fault_supervisor_pkg::TRIG_EXTERNAL_POWER_GOOD_IN: ext_trig = external_power_good_in;
            fault_supervisor_pkg::TRIG_OUTS_GOOD: ext_trig = &out_good;
            default: ext_trig = 1'b1;
        endcase
    end
    assign ext_target = 32'(ext_delay_ms) * 32'(SEQ_DLY_UNIT_CYC);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ext_cnt_ff <= 32'h0;
            external_supply_enable_out <= 1'b0;
        end else if (!(state_ff == ST_UP || state_ff == ST_RUN) || !ext_trig) begin
            ext_cnt_ff <= 32'h0;
            external_supply_enable_out <= external_supply_enable_out &&
                                          (state_ff == ST_UP || state_ff == ST_RUN);
        end else if (ext_cnt_ff >= ext_target) begin
            external_supply_enable_out <= 1'b1;
        end else begin
            ext_cnt_ff <= ext_cnt_ff + 32'h1;
        end
    end

    // system reset: low on any uv/ov, release after programmed delay
    assign rst_target = 32'(RST_STEP_CYC) * (32'(reset_release_delay >
                        3'(fault_supervisor_pkg::RST_DLY_MAX_CODE) ?
                        3'(fault_supervisor_pkg::RST_DLY_MAX_CODE) : reset_release_delay) + 32'h1);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_cnt_ff <= 32'h0;
            system_reset_out_n <= 1'b0;
        end else if ((|uvov_any) || !(&out_good) || !inlet_fet_gate) begin
            rst_cnt_ff <= 32'h0;
            system_reset_out_n <= 1'b0;
        end else if (rst_cnt_ff >= rst_target - 32'h1) begin
            system_reset_out_n <= 1'b1;
        end else begin
            rst_cnt_ff <= rst_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= !(|(fault_status | fault_cond));
        end
    end

    // general pin muxing; led only on pins three and four
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            logic [2:0] fn;
            assign fn = pin_function[gi*3 +: 3];
            always_comb begin
                unique case (fn)
                    fault_supervisor_pkg::FN_SEQ_OUT: pin_drive[gi] = external_supply_enable_out;
                    fault_supervisor_pkg::FN_RESET: pin_drive[gi] = system_reset_out_n;
                    fault_supervisor_pkg::FN_IRQ: pin_drive[gi] = interrupt_out_n;
                    fault_supervisor_pkg::FN_LED: pin_drive[gi] = (gi >= 2) ? pin_gpio_out[gi] : 1'b1;
                    fault_supervisor_pkg::FN_GPIO: pin_drive[gi] = pin_gpio_out[gi];
                    default: pin_drive[gi] = 1'b1; // input functions
                endcase
            end
            assign pin_od[gi] = (gi >= 2) || !pin_push_pull[gi];
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b0;
                end else begin
                    pin_out[gi] <= pin_drive[gi];
                    pin_oe[gi] <= (fn == fault_supervisor_pkg::FN_SEQ_OUT ||
                                   fn == fault_supervisor_pkg::FN_RESET ||
                                   fn == fault_supervisor_pkg::FN_IRQ ||
                                   fn == fault_supervisor_pkg::FN_GPIO ||
                                   (fn == fault_supervisor_pkg::FN_LED && gi >= 2)) &&
                                  (!pin_od[gi] || !pin_drive[gi]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_trip_goes_off: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_ff == ST_RUN && global_trip && input_voltage_sense_ok && !input_voltage_sense_ov)
        |=> state_ff == ST_OFF) else $error("trip did not turn outputs off");
    a_off_all_low: assert property (@(posedge core_clk) disable iff (!resetn)
        state_ff == ST_OFF |=> out_enable == 5'h0) else $error("output on while off");
    a_flag_live: assert property (@(posedge core_clk) disable iff (!resetn)
        1'b1 |=> uvov_flag == $past(uvov_any)) else $error("uvov flag not live");
    a_reset_on_uvov: assert property (@(posedge core_clk) disable iff (!resetn)
        |uvov_any |=> !system_reset_out_n) else $error("reset not low on uvov");
    a_hard_limit_off: assert property (@(posedge core_clk) disable iff (!resetn)
        buck_hard_limit[0] |=> !out_enable[0]) else $error("buck not disabled");
    a_gate_ov_off: assert property (@(posedge core_clk) disable iff (!resetn)
        input_voltage_sense_ov |=> !inlet_fet_gate) else $error("inlet fet on in ov");
    a_irq_cur_warn: assert property (@(posedge core_clk) disable iff (!resetn)
        (input_current_warn && !input_current_warn_mask) |=> !interrupt_out_n)
        else $error("no interrupt on input current warn");
    a_irq_holds: assert property (@(posedge core_clk) disable iff (!resetn)
        (fault_status != 8'h0 && !status_read) |=> !interrupt_out_n)
        else $error("interrupt released before read");
    a_pin_od_high: assert property (@(posedge core_clk) disable iff (!resetn)
        pin_oe[3:2] != 2'h0 |-> (pin_out[3:2] & pin_oe[3:2]) == 2'h0)
        else $error("pin three or four driven high");
endmodule : pmic_fault_supervisor

//--- rtl/fault_supervisor_pkg.sv
// package for the pmic fault supervisor: timing counts, output and pin counts, pin functions
// assumes a single 125 MHz core clock
package fault_supervisor_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_OUT = 5; // three bucks then two ldos
    localparam int unsigned NUM_BUCK = 3;
    localparam int unsigned NUM_PIN = 4;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned GLOBAL_OFF_MS = 100;
    localparam int unsigned BUCK_RESTART_MS = 14;
    localparam int unsigned PWR_FILTER_US = 10;
    localparam int unsigned GLOBAL_OFF_CYC = GLOBAL_OFF_MS * 1000 * CLK_MHZ;
    localparam int unsigned BUCK_RESTART_CYC = BUCK_RESTART_MS * 1000 * CLK_MHZ;
    localparam int unsigned PWR_FILTER_CYC = PWR_FILTER_US * CLK_MHZ;
    localparam int unsigned RST_DLY_MIN_MS = 20;
    localparam int unsigned RST_DLY_STEP_MS = 20; // code 0..4 gives 20..100 ms
    localparam int unsigned RST_DLY_MAX_CODE = 4;
    localparam int unsigned RST_STEP_CYC = RST_DLY_STEP_MS * 1000 * CLK_MHZ;
    localparam int unsigned SEQ_DLY_UNIT_CYC = 1000 * CLK_MHZ; // external enable delay, 1 ms per step
    localparam logic [4:0] WARN_CYCLES = 5'h10; // more than 16 switching cycles at 75%
    localparam int unsigned CNT_W = 32;
    // ------------------------------------------------------------
    // general pin functions
    // ------------------------------------------------------------
    localparam logic [2:0] FN_SEQ_IN = 3'h0;
    localparam logic [2:0] FN_SEQ_OUT = 3'h1;
    localparam logic [2:0] FN_RESET = 3'h2;
    localparam logic [2:0] FN_IRQ = 3'h3;
    localparam logic [2:0] FN_DVS = 3'h4;
    localparam logic [2:0] FN_VSEL = 3'h5;
    localparam logic [2:0] FN_LED = 3'h6;
    localparam logic [2:0] FN_GPIO = 3'h7;
    // power-up sequence trigger selects for the external enable
    localparam logic [1:0] TRIG_START = 2'h0;
    localparam logic [1:0] TRIG_EXTERNAL_POWER_GOOD_IN = 2'h1;
    localparam logic [1:0] TRIG_OUTS_GOOD = 2'h2;
endpackage : fault_supervisor_pkg

//--- tb/status_host.sv
// host side model: reads the fault status whenever the interrupt line is low
// assumes one read strobe per read, spaced so the block sees each read once
`timescale 1ns/1ns
module status_host (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic interrupt_out_n,
    output logic status_read
);
    logic [1:0] gap_ff;

    // one read pulse every four cycles while the interrupt is asserted
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gap_ff <= 2'h0;
            status_read <= 1'b0;
        end else begin
            gap_ff <= gap_ff + 2'h1;
            status_read <= !interrupt_out_n && (gap_ff == 2'h0);
        end
    end
endmodule : status_host

//--- tb/tb.sv
// testbench for the fault supervisor: directed checks of flags, status, interrupt, reset
// assumes shortened off and restart counts handed to the block as parameters
`timescale 1ns/1ns
module tb;
    logic core_clk = 1'b0, resetn = 1'b0, therm_warn = 1'b0, therm_shut = 1'b0;
    logic [4:0] out_uv = 5'h00, out_ov = 5'h00, out_good = 5'h1f, uvov_mask = 5'h1f;
    logic [2:0] buck_warn_level = 3'h0, buck_sw_tick = 3'h0, buck_hard_limit = 3'h0;
    logic [1:0] ldo_limit = 2'h0, ext_trigger_sel = 2'h0;
    logic [4:0] oc_mask = 5'h1f;
    logic therm_warn_mask = 1'b1, therm_shut_mask = 1'b1, input_voltage_sense_ok = 1'b1;
    logic input_voltage_sense_ov = 1'b0, input_current_warn = 1'b0;
    logic input_current_warn_mask = 1'b1, input_below_monitor = 1'b0;
    logic input_monitor_mask = 1'b1, status_read, power_request_in = 1'b1;
    logic external_power_good_in = 1'b1;
    logic [2:0] reset_release_delay = 3'h0;
    logic [3:0] ext_delay_ms = 4'h1, pin_push_pull = 4'h0, pin_gpio_out = 4'h0, pin_in = 4'h0;
    logic [11:0] pin_function = 12'h000;
    logic [4:0] out_enable, uvov_flag;
    logic [2:0] buck_oc_flag;
    logic therm_warn_flag, therm_shut_flag, interrupt_out_n, system_reset_out_n;
    logic inlet_fet_gate, external_supply_enable_out, deep_sleep_state;
    logic [7:0] fault_status;
    logic [3:0] pin_out, pin_oe;
    int error_cnt = 0, checked = 0, cycles = 0;

    // ------------------------------------------------------------
    // block, host and clock
    // ------------------------------------------------------------
    pmic_fault_supervisor #(.GLOBAL_OFF_CYC(50), .BUCK_RESTART_CYC(20), .RST_STEP_CYC(10),
        .SEQ_DLY_UNIT_CYC(5)) pmic_fault_supervisor_i (.core_clk, .resetn, .out_uv, .out_ov,
        .out_good, .uvov_mask, .buck_warn_level, .buck_sw_tick, .buck_hard_limit, .ldo_limit,
        .oc_mask, .therm_warn, .therm_shut, .therm_warn_mask, .therm_shut_mask,
        .input_voltage_sense_ok, .input_voltage_sense_ov, .input_current_warn,
        .input_current_warn_mask, .input_below_monitor, .input_monitor_mask, .status_read,
        .power_request_in, .reset_release_delay, .ext_trigger_sel, .ext_delay_ms, .pin_function,
        .pin_push_pull, .pin_gpio_out, .pin_in, .external_power_good_in, .out_enable, .uvov_flag,
        .buck_oc_flag, .therm_warn_flag, .therm_shut_flag, .fault_status, .interrupt_out_n,
        .system_reset_out_n, .inlet_fet_gate, .external_supply_enable_out, .deep_sleep_state,
        .pin_out, .pin_oe);
    status_host status_host_i (.core_clk, .resetn, .interrupt_out_n, .status_read);
    always #4 core_clk = ~core_clk;

    // cycle ceiling against a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask : step

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for the interrupt to reach a level
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (interrupt_out_n !== lvl && n < 300) begin
            step(1);
            n++;
        end
        check({7'h00, interrupt_out_n}, {7'h00, lvl});
    endtask : wait_irq

    task automatic final_report();
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic uv_trip();
        uvov_mask = 5'h00;
        out_uv = 5'h01;
        step(2);
        check({3'h0, uvov_flag}, 8'h01);
        check(fault_status & 8'h08, 8'h08);
        check({7'h00, system_reset_out_n}, 8'h00);
        check({3'h0, out_enable}, 8'h00);
        check({7'h00, interrupt_out_n}, 8'h00);
        step(8);
        check(fault_status & 8'h08, 8'h08);
        out_uv = 5'h00;
        wait_irq(1'b1);
        check(fault_status, 8'h00);
        check({3'h0, out_enable}, 8'h00);
        step(60);
        check({3'h0, out_enable}, 8'h1f);
        check({7'h00, system_reset_out_n}, 8'h01);
    endtask : uv_trip

    task automatic masked_ov();
        uvov_mask = 5'h1f;
        out_ov = 5'h02;
        step(3);
        check({3'h0, uvov_flag}, 8'h02);
        check({fault_status[3], 6'h00, interrupt_out_n}, 8'h01);
        check({7'h00, system_reset_out_n}, 8'h00);
        out_ov = 5'h00;
        step(2);
    endtask : masked_ov

    task automatic input_ov();
        input_voltage_sense_ov = 1'b1;
        step(2);
        check({7'h00, inlet_fet_gate}, 8'h00);
        check(fault_status, 8'h00);
        input_voltage_sense_ov = 1'b0;
        step(300);
        check({7'h00, inlet_fet_gate}, 8'h01);
    endtask : input_ov

    task automatic current_warn();
        input_current_warn = 1'b1;
        step(3);
        check({fault_status[6], 6'h00, interrupt_out_n}, 8'h01);
        input_current_warn_mask = 1'b0;
        step(2);
        check({fault_status[6], 6'h00, interrupt_out_n}, 8'h80);
        input_current_warn = 1'b0;
        wait_irq(1'b1);
        therm_warn = 1'b1;
        step(3);
        check({therm_warn_flag, 6'h00, interrupt_out_n}, 8'h81);
        therm_warn = 1'b0;
    endtask : current_warn

    task automatic buck_warn();
        oc_mask = 5'h00;
        buck_warn_level = 3'h1;
        for (int i = 0; i < 17; i++) begin
            if (i == 16) check({5'h00, buck_oc_flag}, 8'h00);
            buck_sw_tick = 3'h1;
            step(1);
            buck_sw_tick = 3'h0;
            step(1);
        end
        step(1);
        check({5'h00, buck_oc_flag}, 8'h01);
        check(fault_status & 8'h04, 8'h04);
        buck_warn_level = 3'h0;
        wait_irq(1'b1);
    endtask : buck_warn

    // buck 0 over the hard limit: off alone, back after the restart count
    task automatic hard_limit();
        buck_hard_limit = 3'h1;
        step(2);
        check({3'h0, out_enable}, 8'h1e);
        buck_hard_limit = 3'h0;
        step(10);
        check({3'h0, out_enable}, 8'h1e);
        step(15);
        check({3'h0, out_enable}, 8'h1f);
    endtask : hard_limit

    // unmasked thermal shutdown turns every output and the external enable off
    task automatic therm_shutdown();
        therm_shut_mask = 1'b0;
        therm_shut = 1'b1;
        step(2);
        check({therm_shut_flag, external_supply_enable_out, 1'b0, out_enable}, 8'h80);
        therm_shut = 1'b0;
    endtask : therm_shutdown

    // filtered power request, external enable after restart, pin functions
    task automatic sleep_and_pins();
        pin_function = 12'hc32;
        pin_push_pull = 4'hf;
        step(1300);
        check({external_supply_enable_out, 6'h00, deep_sleep_state}, 8'h80);
        check({pin_out, pin_oe}, 8'h79);
    endtask : sleep_and_pins

    // reset, then every scenario in turn
    initial begin
        step(10);
        resetn = 1'b1;
        step(300);
        check({7'h00, deep_sleep_state}, 8'h01);
        uv_trip();
        step(100);
        masked_ov();
        input_ov();
        current_warn();
        buck_warn();
        hard_limit();
        therm_shutdown();
        sleep_and_pins();
        final_report();
    end
endmodule : tb
